// ===== bench/link_master.sv
// Behavioural two-wire bus master that drives the link for the bench
`timescale 1ns/1ps
module link_master (
	// Clock
	input wire logic clock,
	// Resolved data wire
	input wire logic sda_wire,
	// Driven lines
	output logic scl,
	output logic sda_pull
);
	// ==========================================================
	// Line state and helpers
	logic framed;
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
		framed = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask
	// Start: data falls while the clock is high; a repeated start frees data first
	task automatic start();
		if (framed) begin
			scl <= 1'b0;
			tick(2);
			sda_pull <= 1'b0;
			tick(2);
			scl <= 1'b1;
		end
		tick(4);
		sda_pull <= 1'b1;
		tick(4);
		framed = 1'b1;
	endtask
	// Stop: data rises while the clock is high, then the clock stands still
	task automatic stop();
		scl <= 1'b0;
		tick(2);
		sda_pull <= 1'b1;
		tick(2);
		scl <= 1'b1;
		tick(4);
		sda_pull <= 1'b0;
		tick(4);
		framed = 1'b0;
	endtask
	// Data only changes while the clock is low
	task automatic send_bit(input logic b);
		scl <= 1'b0;
		tick(2);
		sda_pull <= !b;
		tick(2);
		scl <= 1'b1;
		tick(4);
	endtask
	// Release the wire and sample late in the high phase
	task automatic read_bit(output logic b);
		scl <= 1'b0;
		tick(2);
		sda_pull <= 1'b0;
		tick(2);
		scl <= 1'b1;
		tick(3);
		b = sda_wire;
		tick(1);
	endtask
	// Byte out, most significant bit first, then the ninth slot
	task automatic send_byte(input logic [7:0] d, output logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) send_bit(d[i]);
		read_bit(b);
		ack = !b;
	endtask
	// Byte in, then acknowledge low or leave high to end the read
	task automatic recv_byte(output logic [7:0] d, input logic ack);
		logic b;
		for (int i = 7; i >= 0; i--) begin
			read_bit(b);
			d[i] = b;
		end
		send_bit(!ack);
	endtask
endmodule

// ===== bench/test_eeprom_engine.sv
// Self-checking bench for the two-wire EEPROM instruction engine
`timescale 1ns/1ps
module test_eeprom_engine;
	// ==========================================================
	// Signals and instances
	localparam int WC = 200;
	localparam logic [3:0] TA = eeprom_pkg::TYPE_ARRAY;
	localparam logic [3:0] TI = eeprom_pkg::TYPE_ID;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic wp = 1'b0;
	logic cs = 1'b1;
	logic scl;
	logic sda_pull;
	logic sda_out;
	logic sda_oe;
	logic busy;
	logic locked;
	logic sda_wire;
	int err_total = 0;
	int total_checks = 0;
	always #25 clock = ~clock;
	// Open-drain wire with pull-up
	assign sda_wire = !(sda_pull || (sda_oe && !sda_out));
	link_master m (.clock(clock), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));
	eeprom_engine #(.WRITE_CYCLES(WC)) dut (.clock(clock), .reset_n(reset_n), .scl_in(scl),
		.sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect_input(wp),
		.chip_select_address(cs), .write_busy(busy), .id_page_locked(locked));
	// ==========================================================
	// Compare and closing tasks
	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask
	task automatic complete_run();
		if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// ==========================================================
	// Transfer tasks
	function automatic logic [7:0] sel(logic [3:0] ty, logic c, logic [1:0] hi, logic rw);
		return {ty, c, hi, rw};
	endfunction
	task automatic header(input logic [3:0] ty, input logic [9:0] addr);
		logic a;
		m.start();
		m.send_byte(sel(ty, 1'b1, addr[9:8], 1'b0), a);
		chk_bit(a, 1'b1);
		m.send_byte(addr[7:0], a);
		chk_bit(a, 1'b1);
	endtask
	task automatic wr(input logic [3:0] ty, input logic [9:0] addr, input logic [7:0] d[$],
		input logic ok);
		logic a;
		header(ty, addr);
		foreach (d[i]) begin
			m.send_byte(d[i], a);
			chk_bit(a, ok);
		end
		m.stop();
	endtask
	task automatic rd(input logic [3:0] ty, input logic [9:0] addr, input logic [7:0] e[$]);
		logic a;
		logic [7:0] got;
		header(ty, addr);
		m.start();
		m.send_byte(sel(ty, 1'b1, addr[9:8], 1'b1), a);
		chk_bit(a, 1'b1);
		foreach (e[i]) begin
			m.recv_byte(got, i < e.size() - 1);
			chk_byte(got, e[i]);
		end
		m.stop();
		chk_bit(sda_oe, 1'b0);
	endtask
	task automatic cur_rd(input logic [7:0] e);
		logic a;
		logic [7:0] got;
		m.start();
		m.send_byte(sel(TA, 1'b1, 2'b00, 1'b1), a);
		chk_bit(a, 1'b1);
		m.recv_byte(got, 1'b0);
		chk_byte(got, e);
		m.stop();
	endtask
	task automatic poll(input logic [3:0] ty, input logic c, input logic exp);
		logic a;
		m.start();
		m.send_byte(sel(ty, c, 2'b00, 1'b0), a);
		chk_bit(a, exp);
		m.stop();
	endtask
	task automatic lock_status(input logic exp);
		logic a;
		header(TI, 10'h000);
		m.send_byte(8'h00, a);
		chk_bit(a, exp);
		m.start();
		m.stop();
	endtask
	// Times the write cycle and watches the data line stay released
	task automatic wait_cycle();
		int n;
		logic drove;
		n = 0;
		drove = 1'b0;
		for (int k = 0; k < 30 && busy !== 1'b1; k++) @(negedge clock);
		while (busy === 1'b1 && n < 1000) begin
			drove = drove | sda_oe;
			n++;
			@(negedge clock);
		end
		chk_bit(drove, 1'b0);
		chk_byte(8'(n), 8'(WC));
	endtask
	task automatic no_busy(input int n);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(negedge clock);
			seen = seen | busy;
		end
		chk_bit(seen, 1'b0);
	endtask
	// ==========================================================
	// Test sequence
	initial begin
		repeat (10) @(posedge clock);
		reset_n <= 1'b1;
		@(negedge clock);
		chk_bit(busy, 1'b0);
		chk_bit(locked, 1'b0);
		m.tick(8);
		wr(TA, 10'h001, '{8'h99}, 1'b1);
		fork
			wait_cycle();
			begin
				m.tick(10);
				poll(TA, 1'b1, 1'b0);
			end
		join
		poll(TA, 1'b1, 1'b1);
		wr(TA, 10'h00D, '{8'h11, 8'h22, 8'h33, 8'h44}, 1'b1);
		wait_cycle();
		cur_rd(8'h99);
		rd(TA, 10'h00D, '{8'h11, 8'h22, 8'h33});
		wr(TA, 10'h3FF, '{8'h77}, 1'b1);
		wait_cycle();
		rd(TA, 10'h3FF, '{8'h77, 8'h44});
		wp <= 1'b1;
		wr(TA, 10'h005, '{8'h55, 8'h56}, 1'b0);
		m.tick(250);
		rd(TA, 10'h005, '{8'hFF, 8'hFF});
		rd(TA, 10'h001, '{8'h99});
		wp <= 1'b0;
		header(TA, 10'h006);
		m.stop();
		no_busy(40);
		poll(4'h5, 1'b1, 1'b0);
		poll(TA, 1'b0, 1'b0);
		wr(TI, 10'h003, '{8'hC1, 8'hC2}, 1'b1);
		wait_cycle();
		rd(TI, 10'h000, '{8'h5A, 8'h3C, 8'h01, 8'hC1, 8'hC2});
		lock_status(1'b1);
		no_busy(40);
		rd(TI, 10'h000, '{8'h5A});
		wr(TI, 10'h080, '{8'h02}, 1'b1);
		wait_cycle();
		chk_bit(locked, 1'b1);
		lock_status(1'b0);
		wr(TI, 10'h004, '{8'hEE}, 1'b0);
		m.tick(250);
		rd(TI, 10'h004, '{8'hC2});
		chk_bit(locked, 1'b1);
		complete_run();
	end
	// Watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge clock);
		err_total++;
		complete_run();
	end
endmodule

// ===== hw/eeprom_engine.sv
// Two-wire serial EEPROM slave: instruction decode, storage and write cycle
`timescale 1ns/1ps
module eeprom_engine #(
	parameter int WRITE_CYCLES = eeprom_pkg::WRITE_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Serial link
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	// Straps
	input wire logic write_protect_input,
	input wire logic chip_select_address,
	// Status
	output logic write_busy,
	output logic id_page_locked
);

	// ==========================================================
	// Pin synchronisers
	sync_if scl_s ();
	sync_if sda_s ();
	sync_if wp_s ();
	sync_if cs_s ();
	assign scl_s.raw = scl_in;
	assign sda_s.raw = sda_in;
	assign wp_s.raw = write_protect_input;
	assign cs_s.raw = chip_select_address;
	pin_filter #(.RESET_LEVEL(1'b1)) scl_f (.clock(clock), .reset_n(reset_n), .pin(scl_s));
	pin_filter #(.RESET_LEVEL(1'b1)) sda_f (.clock(clock), .reset_n(reset_n), .pin(sda_s));
	pin_filter #(.RESET_LEVEL(1'b0)) wp_f (.clock(clock), .reset_n(reset_n), .pin(wp_s));
	pin_filter #(.RESET_LEVEL(1'b0)) cs_f (.clock(clock), .reset_n(reset_n), .pin(cs_s));

	logic start_det;
	logic stop_det;
	logic sda_now;
	assign start_det = scl_s.level & sda_s.fall;
	assign stop_det = scl_s.level & sda_s.rise;
	// Level the data filter accepts this cycle; our own ack release reaches the wire
	// as the clock rises, so both edges leave the filters in the same cycle
	assign sda_now = sda_s.level ^ (sda_s.rise | sda_s.fall);

	// ==========================================================
	// Storage
	logic [7:0] mem [eeprom_pkg::ARRAY_BYTES];
	logic [7:0] id_page [eeprom_pkg::PAGE_BYTES];
	logic [7:0] page_buf [eeprom_pkg::PAGE_BYTES];

	// ==========================================================
	// State
	eeprom_pkg::bus_state_t state, next_state;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] shifter, next_shifter;
	logic [7:0] rd_byte, next_rd_byte;
	logic [9:0] addr_cnt, next_addr_cnt;
	logic [9:0] last, next_last;
	logic [1:0] sel_hi, next_sel_hi;
	logic [15:0] mask, next_mask;
	logic sel_id, next_sel_id;
	logic lock_op, next_lock_op;
	logic lock_req, next_lock_req;
	logic pending, next_pending;
	logic armed, next_armed;
	logic next_sda_oe;
	logic busy, next_busy;
	logic locked, next_locked;
	logic [eeprom_pkg::WC_W-1:0] wc_cnt, next_wc_cnt;
	logic [15:0] commit_mask, next_commit_mask;
	logic [9:0] commit_last, next_commit_last;
	logic [5:0] commit_page, next_commit_page;
	logic commit_id, next_commit_id;
	logic commit_lock, next_commit_lock;
	logic buf_we;
	logic mem_we;
	logic id_we;
	logic cycle_done;
	logic write_go;
	logic ack_now;
	logic [7:0] rd_src;
	logic [3:0] commit_idx;

	// Byte presented on reads; write protect takes no part here
	assign rd_src = sel_id ? id_page[addr_cnt[3:0]] : mem[addr_cnt];
	assign write_go = stop_det & armed & pending & (state == eeprom_pkg::st_wdata);
	assign commit_idx = wc_cnt[3:0];

	// Acknowledge decision for the byte just received
	always_comb begin
		ack_now = 1'b0;
		case (state)
			eeprom_pkg::st_select: begin
				ack_now = (shifter[7:4] == eeprom_pkg::TYPE_ARRAY
					|| shifter[7:4] == eeprom_pkg::TYPE_ID)
					&& shifter[eeprom_pkg::SEL_CS_BIT] == cs_s.level && !busy;
			end
			eeprom_pkg::st_address: begin
				ack_now = 1'b1;
			end
			eeprom_pkg::st_wdata: begin
				ack_now = !wp_s.level && !(sel_id && locked);
			end
			default: begin
				ack_now = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// Bus protocol next state
	always_comb begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_shifter = shifter;
		next_rd_byte = rd_byte;
		next_addr_cnt = addr_cnt;
		next_last = last;
		next_sel_hi = sel_hi;
		next_mask = mask;
		next_sel_id = sel_id;
		next_lock_op = lock_op;
		next_lock_req = lock_req;
		next_pending = pending;
		next_armed = armed;
		next_sda_oe = sda_oe;
		buf_we = 1'b0;
		if (cycle_done && commit_mask != 16'h0000) begin
			next_addr_cnt = 10'(commit_last + 10'h001);
		end
		if (start_det) begin
			// Start drops any unfinished write header
			next_state = eeprom_pkg::st_select;
			next_bit_cnt = 4'h0;
			next_sda_oe = 1'b0;
			next_pending = 1'b0;
			next_armed = 1'b0;
		end else if (stop_det) begin
			next_state = eeprom_pkg::st_idle;
			next_sda_oe = 1'b0;
			next_armed = 1'b0;
			next_pending = 1'b0;
		end else begin
			case (state)
				eeprom_pkg::st_select, eeprom_pkg::st_address, eeprom_pkg::st_wdata: begin
					if (scl_s.rise && bit_cnt < eeprom_pkg::BITS_PER_BYTE) begin
						next_shifter = {shifter[6:0], sda_now};
						next_bit_cnt = 4'(bit_cnt + 4'h1);
						// The first rise after a data ack is the slot a stop may follow
						if (bit_cnt != 4'h0) begin
							next_armed = 1'b0;
						end
					end else if (scl_s.fall && bit_cnt == eeprom_pkg::BITS_PER_BYTE) begin
						// Ninth slot: pull low to acknowledge
						next_sda_oe = ack_now;
						next_bit_cnt = eeprom_pkg::ACK_SLOT;
						if (state == eeprom_pkg::st_select) begin
							next_sel_id = shifter[7:4] == eeprom_pkg::TYPE_ID;
							next_sel_hi = shifter[2:1];
							if (!ack_now) begin
								next_state = eeprom_pkg::st_idle;
							end
						end else if (state == eeprom_pkg::st_address) begin
							next_mask = 16'h0000;
							next_lock_req = 1'b0;
							if (sel_id) begin
								next_lock_op = shifter[eeprom_pkg::ADDR_A7_BIT];
								next_addr_cnt = {6'h00, shifter[3:0]};
							end else begin
								next_lock_op = 1'b0;
								next_addr_cnt = {sel_hi, shifter};
							end
						end else begin
							if (ack_now) begin
								next_pending = 1'b1;
								if (lock_op) begin
									next_lock_req = shifter[eeprom_pkg::LOCK_DATA_BIT];
								end else begin
									buf_we = 1'b1;
									next_mask[addr_cnt[3:0]] = 1'b1;
									next_last = addr_cnt;
								end
							end
							// Advance inside the page only
							next_addr_cnt = {addr_cnt[9:4], 4'(addr_cnt[3:0] + 4'h1)};
						end
					end else if (scl_s.fall && bit_cnt == eeprom_pkg::ACK_SLOT) begin
						next_sda_oe = 1'b0;
						next_bit_cnt = 4'h0;
						if (state == eeprom_pkg::st_select) begin
							if (shifter[eeprom_pkg::SEL_RW_BIT]) begin
								next_state = eeprom_pkg::st_rdata;
								next_rd_byte = rd_src;
								next_sda_oe = ~rd_src[7];
							end else begin
								next_state = eeprom_pkg::st_address;
							end
						end else if (state == eeprom_pkg::st_address) begin
							next_state = eeprom_pkg::st_wdata;
						end else begin
							next_armed = 1'b1;
						end
					end
				end
				eeprom_pkg::st_rdata: begin
					if (scl_s.rise) begin
						if (bit_cnt < eeprom_pkg::BITS_PER_BYTE) begin
							next_bit_cnt = 4'(bit_cnt + 4'h1);
						end else if (sda_now) begin
							next_state = eeprom_pkg::st_idle;
						end else begin
							next_bit_cnt = eeprom_pkg::ACK_SLOT;
						end
					end else if (scl_s.fall) begin
						if (bit_cnt == eeprom_pkg::BITS_PER_BYTE) begin
							// Release for the master's acknowledge
							next_sda_oe = 1'b0;
							next_addr_cnt = 10'(addr_cnt + 10'h001);
						end else if (bit_cnt == eeprom_pkg::ACK_SLOT) begin
							next_rd_byte = rd_src;
							next_sda_oe = ~rd_src[7];
							next_bit_cnt = 4'h0;
						end else if (bit_cnt != 4'h0) begin
							next_rd_byte = {rd_byte[6:0], 1'b0};
							next_sda_oe = ~rd_byte[6];
						end
					end
				end
				default: begin
					next_sda_oe = 1'b0;
				end
			endcase
		end
	end

	// ==========================================================
	// Internal write cycle next state
	always_comb begin
		next_busy = busy;
		next_wc_cnt = wc_cnt;
		next_locked = locked;
		next_commit_mask = commit_mask;
		next_commit_last = commit_last;
		next_commit_page = commit_page;
		next_commit_id = commit_id;
		next_commit_lock = commit_lock;
		cycle_done = 1'b0;
		mem_we = 1'b0;
		id_we = 1'b0;
		if (!busy) begin
			if (write_go) begin
				next_busy = 1'b1;
				next_wc_cnt = '0;
				next_commit_mask = mask;
				next_commit_last = last;
				next_commit_page = last[9:4];
				next_commit_id = sel_id;
				next_commit_lock = lock_op & lock_req;
			end
		end else begin
			next_wc_cnt = eeprom_pkg::WC_W'(wc_cnt + 1'b1);
			// One buffered byte per cycle over the first sixteen cycles
			if (wc_cnt < eeprom_pkg::WC_W'(eeprom_pkg::PAGE_BYTES) && commit_mask[commit_idx]) begin
				mem_we = !commit_id;
				id_we = commit_id;
			end
			if (wc_cnt == eeprom_pkg::WC_W'(WRITE_CYCLES - 1)) begin
				next_busy = 1'b0;
				cycle_done = 1'b1;
				next_locked = locked | commit_lock;
			end
		end
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			state <= eeprom_pkg::st_idle;
			bit_cnt <= 4'h0;
			shifter <= 8'h00;
			rd_byte <= 8'h00;
			addr_cnt <= 10'h000;
			last <= 10'h000;
			sel_hi <= 2'h0;
			mask <= 16'h0000;
			sel_id <= 1'b0;
			lock_op <= 1'b0;
			lock_req <= 1'b0;
			pending <= 1'b0;
			armed <= 1'b0;
			sda_oe <= 1'b0;
			busy <= 1'b0;
			wc_cnt <= '0;
			locked <= 1'b0;
			commit_mask <= 16'h0000;
			commit_last <= 10'h000;
			commit_page <= 6'h00;
			commit_id <= 1'b0;
			commit_lock <= 1'b0;
		end else begin
			state <= next_state;
			bit_cnt <= next_bit_cnt;
			shifter <= next_shifter;
			rd_byte <= next_rd_byte;
			addr_cnt <= next_addr_cnt;
			last <= next_last;
			sel_hi <= next_sel_hi;
			mask <= next_mask;
			sel_id <= next_sel_id;
			lock_op <= next_lock_op;
			lock_req <= next_lock_req;
			pending <= next_pending;
			armed <= next_armed;
			sda_oe <= next_sda_oe & ~next_busy;
			busy <= next_busy;
			wc_cnt <= next_wc_cnt;
			locked <= next_locked;
			commit_mask <= next_commit_mask;
			commit_last <= next_commit_last;
			commit_page <= next_commit_page;
			commit_id <= next_commit_id;
			commit_lock <= next_commit_lock;
		end
	end

	// Storage write ports; identification page starts with its code bytes
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < eeprom_pkg::ARRAY_BYTES; i++) begin
				mem[i] <= eeprom_pkg::ERASED;
			end
			for (int i = 0; i < eeprom_pkg::PAGE_BYTES; i++) begin
				id_page[i] <= eeprom_pkg::ERASED;
				page_buf[i] <= eeprom_pkg::ERASED;
			end
			id_page[0] <= eeprom_pkg::ID_CODE0;
			id_page[1] <= eeprom_pkg::ID_CODE1;
			id_page[2] <= eeprom_pkg::ID_CODE2;
		end else begin
			if (buf_we) begin
				page_buf[addr_cnt[3:0]] <= shifter;
			end
			if (mem_we) begin
				mem[{commit_page, commit_idx}] <= page_buf[commit_idx];
			end
			if (id_we) begin
				id_page[commit_idx] <= page_buf[commit_idx];
			end
		end
	end

	assign sda_out = 1'b0;
	assign write_busy = busy;
	assign id_page_locked = locked;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);

	busy_quiet_a: assert property (busy |-> !sda_oe)
		else $error("data line driven during write cycle");
	write_trigger_a: assert property ($rose(busy) |-> $past(write_go))
		else $error("write cycle started without tenth-slot stop");
	cycle_length_a: assert property ($fell(busy) |-> $past(wc_cnt) == eeprom_pkg::WC_W'(WRITE_CYCLES - 1))
		else $error("write cycle ended at wrong count");
	lock_sticky_a: assert property (locked |=> locked)
		else $error("lock flag cleared");
	wp_nack_a: assert property ((state == eeprom_pkg::st_wdata && bit_cnt == eeprom_pkg::ACK_SLOT && wp_s.level) |-> !sda_oe)
		else $error("data byte acked while protected");
	locked_nack_a: assert property ((state == eeprom_pkg::st_wdata && bit_cnt == eeprom_pkg::ACK_SLOT && sel_id && locked) |-> !sda_oe)
		else $error("locked page data acked");
	select_ack_a: assert property ((state == eeprom_pkg::st_select && bit_cnt == eeprom_pkg::ACK_SLOT && sda_oe) |-> (shifter[7:5] == 3'h5 && shifter[eeprom_pkg::SEL_CS_BIT] == cs_s.level && !busy))
		else $error("bad select acked");
	master_nack_a: assert property ((state == eeprom_pkg::st_rdata && bit_cnt == eeprom_pkg::BITS_PER_BYTE && scl_s.rise && sda_now && !start_det && !stop_det) |=> state == eeprom_pkg::st_idle)
		else $error("output continued after master nack");
	read_step_a: assert property ((state == eeprom_pkg::st_rdata && bit_cnt == eeprom_pkg::BITS_PER_BYTE && scl_s.fall && !start_det && !stop_det && !cycle_done) |=> addr_cnt == 10'($past(addr_cnt) + 10'h001))
		else $error("read counter did not step");
	counter_after_a: assert property ((cycle_done && commit_mask != 16'h0000 && !start_det && !stop_det) |=> addr_cnt == 10'(commit_last + 10'h001))
		else $error("counter not past last written byte");

	write_seen_c: cover property ($fell(busy) && commit_mask != 16'h0000);
	seq_read_c: cover property (state == eeprom_pkg::st_rdata && bit_cnt == eeprom_pkg::ACK_SLOT);
	lock_set_c: cover property ($rose(locked));
	poll_nack_c: cover property (busy && state == eeprom_pkg::st_select && bit_cnt == eeprom_pkg::ACK_SLOT);

endmodule

// ===== hw/eeprom_pkg.sv
// Constants and types shared by the two-wire EEPROM instruction engine
package eeprom_pkg;

	// ==========================================================
	// Timing
	localparam int CLOCK_MHZ = 20;
	localparam int WRITE_TIME_US = 1000;
	localparam int WRITE_CYCLES = WRITE_TIME_US * CLOCK_MHZ;
	localparam int WC_W = 20;

	// ==========================================================
	// Storage geometry
	localparam int ARRAY_BYTES = 1024;
	localparam int ADDR_W = 10;
	localparam int PAGE_BYTES = 16;
	localparam int IN_PAGE_W = 4;
	localparam logic [7:0] ERASED = 8'hFF;

	// Identification code bytes, values arbitrary
	localparam logic [7:0] ID_CODE0 = 8'h5A;
	localparam logic [7:0] ID_CODE1 = 8'h3C;
	localparam logic [7:0] ID_CODE2 = 8'h01;

	// ==========================================================
	// Select byte, address byte and data byte fields
	localparam logic [3:0] TYPE_ARRAY = 4'hA;
	localparam logic [3:0] TYPE_ID = 4'hB;
	localparam int SEL_CS_BIT = 3;
	localparam int SEL_RW_BIT = 0;
	localparam int ADDR_A7_BIT = 7;
	localparam int LOCK_DATA_BIT = 1;

	// ==========================================================
	// Bit slot positions within a byte frame
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic [3:0] ACK_SLOT = 4'h9;

	typedef enum {st_idle, st_select, st_address, st_wdata, st_rdata} bus_state_t;

endpackage

// ===== hw/pin_filter.sv
// Three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
module pin_filter #(
	parameter logic RESET_LEVEL = 1'b1
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset_n,
	// Pin carrier
	sync_if.filter pin
);

	logic ff1;
	logic ff2;
	logic ff3;
	logic level;
	logic next_level;

	// Accept a new level only when the last two stages agree
	always_comb begin
		next_level = level;
		if (ff2 == ff3) begin
			next_level = ff3;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			ff1 <= RESET_LEVEL;
			ff2 <= RESET_LEVEL;
			ff3 <= RESET_LEVEL;
			level <= RESET_LEVEL;
		end else begin
			ff1 <= pin.raw;
			ff2 <= ff1;
			ff3 <= ff2;
			level <= next_level;
		end
	end

	// Edge pulses last one cycle
	assign pin.level = level;
	assign pin.rise = next_level & ~level;
	assign pin.fall = ~next_level & level;

endmodule

// ===== hw/sync_if.sv
// Carrier between a pin filter and its user
`timescale 1ns/1ps
interface sync_if;
	logic raw;
	logic level;
	logic rise;
	logic fall;
	modport filter (input raw, output level, rise, fall);
	modport user (output raw, input level, rise, fall);
endinterface
